// ### rtl/lock_ext_ctrl.sv
// Locked sequence, extension override and trap/interrupt entry control
// Summary of operation
// - Lock instruction binds the next 1 to 4 instructions into one run
// - During a run, interrupts, event transfers and class A traps wait
// - Class B traps are still taken and break into the run
// - Inhibit acts at once after decode; no service before next instruction
// - Each instruction counts once, however many cycles it takes
// - Any instruction type may sit inside a run
// - Lock has no effect while a class B trap flag is set
// - Page and segment overrides inhibit like lock; void under class B flags
// - Normal access uses one of four page pointers and a 14-bit offset
// - Page override substitutes its page number; stored pointers untouched
// - Segment override uses full 16-bit address inside its segment
// - Short modes normally select the standard function register space
// - Redirect steers short-mode accesses to the extended space
// - Combined instructions apply override and redirect together
// - Redirect and combined instructions inhibit like lock
// - Every lock or extension instruction taken with no class B flag set and no class B trap taken in that cycle loads the extension counter
// - A new lock or extension instruction in a run reloads the counter
// - Idle inside a run blocks event transfers during idle
// - Interrupt accepted only when priority is above CPU level
// - Traps are taken regardless of CPU level
// - Entry pushes machine state, then branches to the vector
// - Return pops machine state and resumes where interrupted
`timescale 1ns/1ps
`default_nettype none
`include "lock_ext_map.svh"
module lock_ext_ctrl
   import lock_ext_pkg::*;
(
   input  wire logic                      SYS_CLK_IN,
   input  wire logic                      RST_N_IN,
   input  wire decode_s                   DEC_IN,
   input  wire logic                      INSTR_DONE_IN,
   input  wire logic                      IDLE_ACTIVE_IN,
   input  wire access_s                   ACC_IN,
   input  wire logic [4*`PAGE_W-1:0]      DPP_IN,
   input  wire logic [`TRAPB_W-1:0]       TRAPB_FLAGS_IN,
   input  wire logic                      TRAPA_REQ_IN,
   input  wire logic [`VEC_W-1:0]         TRAPA_VEC_IN,
   input  wire logic                      TRAPB_REQ_IN,
   input  wire logic [`VEC_W-1:0]         TRAPB_VEC_IN,
   input  wire logic                      IRQ_REQ_IN,
   input  wire logic [`PRIO_W-1:0]        IRQ_PRIO_IN,
   input  wire logic [`VEC_W-1:0]         IRQ_VEC_IN,
   input  wire logic                      PEC_REQ_IN,
   input  wire logic [`PRIO_W-1:0]        CPU_PRIO_IN,
   output logic                           LOCKED_OUT,
   output logic                           FETCH_HOLD_OUT,
   output logic [`PHYS_W-1:0]             PHYS_ADDR_OUT,
   output logic                           EXT_SPACE_OUT,
   output logic                           PEC_GRANT_OUT,
   output logic                           IRQ_ACK_OUT,
   output logic                           TRAP_ACK_OUT,
   output logic                           PUSH_STATE_OUT,
   output logic                           POP_STATE_OUT,
   output logic                           BRANCH_OUT,
   output logic [`VEC_W-1:0]              VECTOR_OUT
);
   logic [`CNT_W-1:0]   count;
   logic [`CNT_W-1:0]   next_count;
   logic                page_ovr;
   logic                seg_ovr;
   logic                redir;
   logic [`PAGE_W-1:0]  ovr_page;
   logic [`SEG_W-1:0]   ovr_seg;
   logic                idle_locked;
   logic                idle_was;
   ctl_state_e          state;
   logic [1:0]          step;
   logic                trapb_pending;
   logic                take_ext;
   logic                locked;
   logic                irq_ok;
   logic                any_take;
   logic [`VEC_W-1:0]   take_vec;
   logic [`PAGE_W-1:0]  dpp_page;
   logic [1:0]          dpp_sel;

   assign trapb_pending = |TRAPB_FLAGS_IN;
   // Extension instruction accepted only with no class B flag pending
   assign take_ext = DEC_IN.valid && (DEC_IN.op != OP_NONE)
                     && !trapb_pending;
   // Inhibit is combinational so it covers the decode cycle itself
   assign locked = (count != '0) || take_ext;
   assign irq_ok = IRQ_REQ_IN && (IRQ_PRIO_IN > CPU_PRIO_IN);

   always_comb
   begin
      next_count = count;
      if (take_ext)
      begin
         // Zero operand taken as one; above four clamps to four
         if (DEC_IN.count == '0)
            next_count = `RUN_ONE;
         else if (DEC_IN.count > `RUN_MAX)
            next_count = `RUN_MAX;
         else
            next_count = DEC_IN.count;
      end
      else if (INSTR_DONE_IN && (count != '0))
         next_count = count - `RUN_ONE;
      if (TRAPB_REQ_IN && (state == ST_RUN))
         next_count = '0;
   end

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         count <= '0;
      else
         count <= next_count;
   end

   // Override kind latched at load, dropped when the run ends
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         page_ovr <= 1'b0;
         seg_ovr  <= 1'b0;
         redir    <= 1'b0;
         ovr_page <= '0;
         ovr_seg  <= '0;
      end
      else if (next_count == '0)
      begin
         page_ovr <= 1'b0;
         seg_ovr  <= 1'b0;
         redir    <= 1'b0;
      end
      else if (take_ext)
      begin
         page_ovr <= (DEC_IN.op == OP_PAGE) || (DEC_IN.op == OP_PAGE_RD);
         seg_ovr  <= (DEC_IN.op == OP_SEG) || (DEC_IN.op == OP_SEG_RD);
         redir    <= (DEC_IN.op == OP_REDIR) || (DEC_IN.op == OP_PAGE_RD)
                     || (DEC_IN.op == OP_SEG_RD);
         ovr_page <= DEC_IN.page;
         ovr_seg  <= DEC_IN.seg;
      end
   end

   // Idle entered inside a run keeps event transfers blocked
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         idle_locked <= 1'b0;
      else if (DEC_IN.valid && DEC_IN.idle && locked)
         idle_locked <= 1'b1;
      else if (idle_was && !IDLE_ACTIVE_IN)
         idle_locked <= 1'b0;
   end

   // Previous idle level, so the block ends when idle is left
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         idle_was <= 1'b0;
      else
         idle_was <= IDLE_ACTIVE_IN;
   end

   assign dpp_sel  = ACC_IN.addr[`ADDR_W-1:`DPP_SEL_LSB];
   assign dpp_page = DPP_IN[dpp_sel*`PAGE_W +: `PAGE_W];

   // Address generation, registered
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         PHYS_ADDR_OUT <= '0;
         EXT_SPACE_OUT <= 1'b0;
      end
      else if (ACC_IN.valid)
      begin
         if (seg_ovr)
            PHYS_ADDR_OUT <= {ovr_seg, ACC_IN.addr};
         else if (page_ovr)
            PHYS_ADDR_OUT <= {ovr_page,
                              ACC_IN.addr[`PAGE_OFS_W-1:0]};
         else
            PHYS_ADDR_OUT <= {dpp_page,
                              ACC_IN.addr[`PAGE_OFS_W-1:0]};
         EXT_SPACE_OUT <= ACC_IN.short_mode && redir;
      end
   end

   // Service arbitration: class B first, then class A, then interrupts
   always_comb
   begin
      any_take = 1'b0;
      take_vec = '0;
      if (TRAPB_REQ_IN)
      begin
         any_take = 1'b1;
         take_vec = TRAPB_VEC_IN;
      end
      else if (TRAPA_REQ_IN && !locked)
      begin
         any_take = 1'b1;
         take_vec = TRAPA_VEC_IN;
      end
      else if (irq_ok && !locked)
      begin
         any_take = 1'b1;
         take_vec = IRQ_VEC_IN;
      end
   end

   // Entry: push state then branch; exit: pop state then resume
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         state          <= ST_RUN;
         step           <= '0;
         IRQ_ACK_OUT    <= 1'b0;
         TRAP_ACK_OUT   <= 1'b0;
         PUSH_STATE_OUT <= 1'b0;
         POP_STATE_OUT  <= 1'b0;
         BRANCH_OUT     <= 1'b0;
         VECTOR_OUT     <= '0;
      end
      else
      begin
         IRQ_ACK_OUT  <= 1'b0;
         TRAP_ACK_OUT <= 1'b0;
         BRANCH_OUT   <= 1'b0;
         case (state)
            ST_RUN:
            begin
               if (any_take)
               begin
                  state          <= ST_ENTRY;
                  step           <= `ENTRY_CYC - 2'h1;
                  PUSH_STATE_OUT <= 1'b1;
                  VECTOR_OUT     <= take_vec;
                  TRAP_ACK_OUT   <= TRAPB_REQ_IN || TRAPA_REQ_IN;
                  IRQ_ACK_OUT    <= !TRAPB_REQ_IN && !TRAPA_REQ_IN;
               end
               else if (DEC_IN.valid && DEC_IN.ret)
               begin
                  state         <= ST_EXIT;
                  step          <= `EXIT_CYC - 2'h1;
                  POP_STATE_OUT <= 1'b1;
               end
            end
            ST_ENTRY:
            begin
               if (step == '0)
               begin
                  PUSH_STATE_OUT <= 1'b0;
                  BRANCH_OUT     <= 1'b1;
                  state          <= ST_RUN;
               end
               else
                  step <= step - 2'h1;
            end
            ST_EXIT:
            begin
               if (step == '0)
               begin
                  POP_STATE_OUT <= 1'b0;
                  BRANCH_OUT    <= 1'b1;
                  VECTOR_OUT    <= '0;
                  state         <= ST_RUN;
               end
               else
                  step <= step - 2'h1;
            end
            default:
               state <= ST_RUN;
         endcase
      end
   end

   assign LOCKED_OUT     = locked;
   // Fetch held while the entry or return sequence runs
   assign FETCH_HOLD_OUT = (state != ST_RUN);
   assign PEC_GRANT_OUT  = PEC_REQ_IN && !locked && !idle_locked
                           && !TRAPB_REQ_IN;

   AST_LOCK_BLOCKS_IRQ:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      (count != '0) && !TRAPB_REQ_IN |-> !any_take && !PEC_GRANT_OUT)
      else $error("Request serviced inside locked run");
   AST_TRAPB_BREAKS:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      TRAPB_REQ_IN && (state == ST_RUN) |=> TRAP_ACK_OUT && count == '0)
      else $error("Class B trap not taken");
   AST_DECODE_INHIBIT:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      take_ext && !TRAPB_REQ_IN |=> !IRQ_ACK_OUT && (count != '0))
      else $error("Inhibit not immediate");
   AST_COUNT_HOLDS:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      !INSTR_DONE_IN && !DEC_IN.valid && !TRAPB_REQ_IN |=> $stable(count))
      else $error("Count moved without instruction");
   AST_TRAPB_VOIDS:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      trapb_pending && count == '0 |=> count == '0)
      else $error("Lock took effect with class B flag");
   AST_RELOAD:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      take_ext && DEC_IN.count == 3'h3 && !TRAPB_REQ_IN |=> count == 3'h3)
      else $error("Counter not reloaded");
   AST_PRIO:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      IRQ_ACK_OUT |-> $past(IRQ_PRIO_IN) > $past(CPU_PRIO_IN))
      else $error("Interrupt taken at too low priority");
   AST_ENTRY_SEQ:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      $rose(PUSH_STATE_OUT) |-> ##1 PUSH_STATE_OUT ##1 BRANCH_OUT)
      else $error("Entry order wrong");
   AST_EXIT_SEQ:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      $rose(POP_STATE_OUT) |-> ##2 BRANCH_OUT && !POP_STATE_OUT)
      else $error("Return order wrong");
   AST_END_OVR:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      count == '0 && !take_ext |-> !page_ovr && !seg_ovr && !redir)
      else $error("Override outlived run");
   AST_LOAD_CLAMP:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      take_ext && !TRAPB_REQ_IN |=> (count != '0) && (count <= `RUN_MAX))
      else $error("Run length outside one to four");
   AST_DONE_STEP:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      INSTR_DONE_IN && !take_ext && !TRAPB_REQ_IN && (count != '0)
      |=> count == $past(count) - `RUN_ONE)
      else $error("Count not stepped once per instruction");
   AST_PAGE_ADDR:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      ACC_IN.valid && page_ovr && !seg_ovr
      |=> PHYS_ADDR_OUT[`PHYS_W-1:`PAGE_OFS_W] == $past(ovr_page))
      else $error("Page override not applied");
   AST_SEG_ADDR:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      ACC_IN.valid && seg_ovr
      |=> PHYS_ADDR_OUT == {$past(ovr_seg), $past(ACC_IN.addr)})
      else $error("Segment override not applied");
   AST_SHORT_STD:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      ACC_IN.valid && !redir |=> !EXT_SPACE_OUT)
      else $error("Short access left standard space");
   AST_IDLE_PEC:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      idle_locked |-> !PEC_GRANT_OUT)
      else $error("Event transfer granted in locked idle");
   AST_TRAPA_TAKEN:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      TRAPA_REQ_IN && !TRAPB_REQ_IN && !locked && (state == ST_RUN)
      |=> TRAP_ACK_OUT && (VECTOR_OUT == $past(TRAPA_VEC_IN)))
      else $error("Class A trap not taken");
   AST_FETCH_HOLD:
   assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
      PUSH_STATE_OUT || POP_STATE_OUT |-> FETCH_HOLD_OUT)
      else $error("Fetch not held during entry or exit");
endmodule
`default_nettype wire

// ### rtl/lock_ext_map.svh
// Constants for the locked sequence and extension control block
`ifndef LOCK_EXT_MAP_SVH
`define LOCK_EXT_MAP_SVH
`define CNT_W          3
`define PRIO_W         4
`define PAGE_W         10
`define SEG_W          8
`define ADDR_W         16
`define PHYS_W         24
`define PAGE_OFS_W     14
`define DPP_SEL_LSB    14
`define TRAPB_W        4
`define VEC_W          9
`define RUN_MAX        3'h4
`define RUN_ONE        3'h1
`define ENTRY_CYC      2'h2
`define EXIT_CYC       2'h2
`endif

// ### rtl/lock_ext_pkg.sv
// Types for the locked sequence and extension control block
`default_nettype none
`include "lock_ext_map.svh"
package lock_ext_pkg;
   typedef enum logic [2:0]
   {
      OP_NONE    = 3'h0,
      OP_LOCK    = 3'h1,
      OP_PAGE    = 3'h2,
      OP_SEG     = 3'h3,
      OP_REDIR   = 3'h4,
      OP_PAGE_RD = 3'h5,
      OP_SEG_RD  = 3'h6
   } ext_op_e;
   typedef enum logic [1:0]
   {
      ST_RUN   = 2'h0,
      ST_ENTRY = 2'h1,
      ST_EXIT  = 2'h2
   } ctl_state_e;
   typedef struct packed
   {
      logic                   valid;
      ext_op_e                op;
      logic [`CNT_W-1:0]      count;
      logic [`PAGE_W-1:0]     page;
      logic [`SEG_W-1:0]      seg;
      logic                   idle;
      logic                   ret;
   } decode_s;
   typedef struct packed
   {
      logic                   valid;
      logic                   short_mode;
      logic [`ADDR_W-1:0]     addr;
   } access_s;
endpackage
`default_nettype wire

// ### testbench/lock_ext_ctrl_tb.sv
// Self-checking bench for the locked sequence and extension control
`timescale 1ns/1ps
`default_nettype none
module lock_ext_ctrl_tb
   import lock_ext_pkg::*;
;
   localparam logic [39:0] DATA_PAGE_POINTER = {10'h344, 10'h233, 10'h122, 10'h011};
   localparam logic [8:0]  VA  = 9'h0a8;
   localparam logic [8:0]  VB  = 9'h010;
   localparam logic [8:0]  VI  = 9'h1c4;
   typedef struct packed
   {
      ext_op_e     op;
      logic        sh;
      logic [15:0] a;
      logic [23:0] ph;
      logic        ex;
   } row_s;
   row_s        rows [8];
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        go = 1'b0;
   logic        idle_act = 1'b0;
   logic        trq_a = 1'b0;
   logic        trq_b = 1'b0;
   logic        irq = 1'b0;
   logic        peripheral_event_transfer = 1'b0;
   decode_s     dec = '0;
   access_s     acc = '0;
   logic [3:0]  flags = 4'h0;
   logic [3:0]  iprio = 4'h0;
   logic [3:0]  cprio = 4'h0;
   logic [2:0]  n = 3'h0;
   logic [1:0]  gap = 2'h0;
   logic        done, busy, lk, locked, ext, pgnt, iack, tack, push, pop, br;
   logic        hold;
   logic [23:0] phys;
   logic [8:0]  vec;
   int          n_mismatch = 0;
   int          checked = 0;
   always #10 clk = ~clk;
   lock_ext_ctrl uut
   (
      .SYS_CLK_IN     (clk),
      .RST_N_IN       (rst_n),
      .DEC_IN         (dec),
      .INSTR_DONE_IN  (done),
      .IDLE_ACTIVE_IN (idle_act),
      .ACC_IN         (acc),
      .DPP_IN         (DATA_PAGE_POINTER),
      .TRAPB_FLAGS_IN (flags),
      .TRAPA_REQ_IN   (trq_a),
      .TRAPA_VEC_IN   (VA),
      .TRAPB_REQ_IN   (trq_b),
      .TRAPB_VEC_IN   (VB),
      .IRQ_REQ_IN     (irq),
      .IRQ_PRIO_IN    (iprio),
      .IRQ_VEC_IN     (VI),
      .PEC_REQ_IN     (peripheral_event_transfer),
      .CPU_PRIO_IN    (cprio),
      .LOCKED_OUT     (locked),
      .FETCH_HOLD_OUT (hold),
      .PHYS_ADDR_OUT  (phys),
      .EXT_SPACE_OUT  (ext),
      .PEC_GRANT_OUT  (pgnt),
      .IRQ_ACK_OUT    (iack),
      .TRAP_ACK_OUT   (tack),
      .PUSH_STATE_OUT (push),
      .POP_STATE_OUT  (pop),
      .BRANCH_OUT     (br),
      .VECTOR_OUT     (vec)
   );
   pipe_model pipe
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .go      (go),
      .n_instr (n),
      .gap     (gap),
      .done    (done),
      .busy    (busy)
   );
   task automatic end_of_test();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 40)
      begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   function automatic logic [23:0] std(input logic [15:0] a);
      return {DATA_PAGE_POINTER[a[15:14]*10 +: 10], a[13:0]};
   endfunction
   task automatic put(input ext_op_e op, input logic [2:0] c,
                      input logic [1:0] ir);
      dec = '{1'b1, op, c, 10'h2a5, 8'h3c, ir[1], ir[0]};
      #1 lk = locked;
      @(negedge clk);
      dec.valid = 1'b0;
   endtask
   task automatic look(input logic sh, input logic [15:0] a,
                       input logic [23:0] ph, input logic ex);
      acc = '{1'b1, sh, a};
      @(negedge clk);
      acc.valid = 1'b0;
      chk(phys, ph);
      chk(ext, ex);
   endtask
   task automatic run(input logic [2:0] k, input logic [1:0] g,
                      input logic watch);
      int i;
      n = k;
      gap = g;
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (i = 0; busy && i < 40; i++)
      begin
         if (watch)
            chk({iack, tack, pgnt}, 3'h0);
         @(negedge clk);
      end
      tmo(i);
      @(negedge clk);
   endtask
   task automatic svc(input logic trap, input logic [8:0] v);
      int i;
      for (i = 0; (trap ? tack : iack) !== 1'b1 && i < 40; i++)
         @(negedge clk);
      tmo(i);
      {trq_a, trq_b, irq} = 3'h0;
      chk({vec, push, hold}, {v, 2'h3});
      @(negedge clk);
      chk({push, tack, iack}, 3'h4);
      @(negedge clk);
      chk({push, br, hold}, 3'h2);
   endtask
   task automatic ret();
      put(OP_NONE, 3'h0, 2'h1);
      chk(pop, 1'b1);
      @(negedge clk);
      chk(pop, 1'b1);
      @(negedge clk);
      chk({pop, br, vec}, {2'h1, 9'h0});
   endtask
   initial
   begin
      rows[0] = '{OP_NONE, 1'b1, 16'h8123, {10'h233, 14'h0123}, 1'b0};
      rows[1] = '{OP_LOCK, 1'b1, 16'h4abc, {10'h122, 14'h0abc}, 1'b0};
      rows[2] = '{OP_PAGE, 1'b0, 16'hc7ff, {10'h2a5, 14'h07ff}, 1'b0};
      rows[3] = '{OP_SEG, 1'b1, 16'hfffe, {8'h3c, 16'hfffe}, 1'b0};
      rows[4] = '{OP_REDIR, 1'b1, 16'h0010, {10'h011, 14'h0010}, 1'b1};
      rows[5] = '{OP_PAGE_RD, 1'b1, 16'h3fff, {10'h2a5, 14'h3fff}, 1'b1};
      rows[6] = '{OP_SEG_RD, 1'b1, 16'h0000, {8'h3c, 16'h0000}, 1'b1};
      rows[7] = '{OP_REDIR, 1'b0, 16'h4000, {10'h122, 14'h0000}, 1'b0};
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      chk({locked, push, pop, br, iack, tack, vec}, 15'h0);
      for (int r = 0; r < 8; r++)
      begin
         put(rows[r].op, 3'h1, 2'h0);
         chk(lk, rows[r].op != OP_NONE);
         look(rows[r].sh, rows[r].a, rows[r].ph, rows[r].ex);
         run(3'h1, 2'h0, 1'b0);
         look(rows[r].sh, rows[r].a, std(rows[r].a), 1'b0);
      end
      $display("address mapping test done");
      cprio = 4'h2;
      iprio = 4'h5;
      {irq, trq_a, peripheral_event_transfer} = 3'h7;
      put(OP_LOCK, 3'h3, 2'h0);
      chk({lk, iack, tack, pgnt}, 4'h8);
      run(3'h3, 2'h2, 1'b1);
      chk(locked, 1'b0);
      svc(1'b1, VA);
      chk(pgnt, 1'b1);
      peripheral_event_transfer = 1'b0;
      irq = 1'b1;
      svc(1'b0, VI);
      ret();
      $display("locked run test done");
      iprio = 4'h5;
      cprio = 4'h5;
      irq = 1'b1;
      repeat (6)
      begin
         @(negedge clk);
         chk(iack, 1'b0);
      end
      cprio = 4'h4;
      svc(1'b0, VI);
      ret();
      $display("priority test done");
      put(OP_LOCK, 3'h2, 2'h0);
      run(3'h1, 2'h0, 1'b0);
      put(OP_LOCK, 3'h4, 2'h0);
      run(3'h3, 2'h0, 1'b0);
      chk(locked, 1'b1);
      run(3'h1, 2'h0, 1'b0);
      chk(locked, 1'b0);
      $display("reload test done");
      put(OP_LOCK, 3'h4, 2'h0);
      cprio = 4'hf;
      trq_b = 1'b1;
      svc(1'b1, VB);
      ret();
      flags = 4'h4;
      put(OP_LOCK, 3'h2, 2'h0);
      chk(lk, 1'b0);
      @(negedge clk);
      put(OP_PAGE, 3'h2, 2'h0);
      chk(lk, 1'b0);
      look(1'b0, 16'h8123, std(16'h8123), 1'b0);
      flags = 4'h0;
      $display("class B trap test done");
      put(OP_LOCK, 3'h2, 2'h0);
      @(negedge clk);
      put(OP_NONE, 3'h0, 2'h2);
      idle_act = 1'b1;
      peripheral_event_transfer = 1'b1;
      run(3'h2, 2'h0, 1'b1);
      chk(pgnt, 1'b0);
      idle_act = 1'b0;
      @(negedge clk);
      chk(pgnt, 1'b1);
      peripheral_event_transfer = 1'b0;
      $display("idle test done");
      put(OP_PAGE, 3'h4, 2'h0);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      chk({locked, push, pop, br, iack, tack, vec}, 15'h0);
      look(1'b0, 16'hc7ff, std(16'hc7ff), 1'b0);
      $display("reset test done");
      end_of_test();
   end
endmodule
`default_nettype wire

// ### testbench/pipe_model.sv
// Decode pipeline model that retires instructions with selectable stalls
`timescale 1ns/1ps
`default_nettype none
module pipe_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [2:0] n_instr,
   input  wire logic [1:0] gap,
   output logic            done,
   output logic            busy
);
   logic [2:0] left;
   logic [1:0] wait_cnt;
   assign busy = (left != 3'h0);
   // One pulse per instruction however many cycles it stalls
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         left     <= 3'h0;
         wait_cnt <= 2'h0;
         done     <= 1'b0;
      end
      else if (go)
      begin
         left     <= n_instr;
         wait_cnt <= gap;
      end
      else
      begin
         done <= 1'b0;
         if (busy && wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
         else if (busy)
         begin
            done     <= 1'b1;
            left     <= left - 3'h1;
            wait_cnt <= gap;
         end
      end
   end
endmodule
`default_nettype wire
